// ==== logic/vipu_top.sv ====
// Vectored interrupt priority unit: request flags, APB registers and CPU offer logic
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module vipu_top #(
  parameter int NEST_W = 4
) (
  // Clock, reset and clock enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request sources
  input wire logic [7:0] external_pin_irqs,
  input wire logic [28:0] internal_irqs,
  input wire logic carrier_combined_irq,
  input wire logic watchdog_overflow,
  // CPU side
  input wire logic trap_instruction,
  input wire logic cpu_int_ack,
  input wire logic cpu_reti,
  output logic cpu_int_req,
  output logic [15:0] cpu_vector,
  output logic standby_release,
  output logic sys_reset_req
);

  // Depth counters need at least one bit and stay narrow enough for the status word
  if (NEST_W < 1 || NEST_W > 4)
  begin : g_bad_nest_w
    $error("vipu_top: NEST_W must be 1 to 4");
  end

  vipu_arb_if arb_bus ();

  vipu_arbiter u_arb (
    .arb(arb_bus.arb)
  );

  // State registers
  logic [28:0] req_flags;
  logic [28:0] mask_flag;
  logic [28:0] level_select_flag;
  logic global_enable_flag;
  logic carrier_mode;
  logic undervoltage_reset_select;
  logic trap_pend;
  logic offer_trap;
  logic [4:0] offer_slot;
  logic [NEST_W-1:0] hi_depth;
  logic [NEST_W-1:0] lo_depth;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] pin_prev;
  vipu_pkg::vipu_state_t state;

  // Map source pulses onto slots; any source of a shared slot sets it
  function automatic logic [28:0] map_sources(input logic [28:0] ints, input logic [7:0] pins);
    logic [28:0] res;
    res = '0;
    for (int i = 0; i < vipu_pkg::NUM_INT; i++)
    begin
      res[vipu_pkg::INT_SLOT[i]] = res[vipu_pkg::INT_SLOT[i]] | ints[i];
    end
    for (int j = 0; j < vipu_pkg::NUM_EXT; j++)
    begin
      res[vipu_pkg::EXT_SLOT[j]] = res[vipu_pkg::EXT_SLOT[j]] | pins[j];
    end
    return res;
  endfunction

  // Vector table address of a slot: two bytes per slot from the base
  function automatic logic [15:0] slot_vector(input logic [4:0] slot);
    return vipu_pkg::VEC_BASE + {10'h000, slot, 1'b0};
  endfunction

  // Rising edges of the synchronised pins; edge polarity is fixed here
  wire [7:0] pin_rise = pin_sync & ~pin_prev;

  // Timer8 slot source follows the carrier mode; undervoltage leaves slot 0 when it resets
  wire tm8_src = carrier_mode ? carrier_combined_irq
    : internal_irqs[vipu_pkg::TM8_INT_IDX];
  wire lvi_irq = internal_irqs[vipu_pkg::LVI_INT_IDX] & ~undervoltage_reset_select;
  wire [28:0] int_src = {internal_irqs[28:25], tm8_src, internal_irqs[23:1], lvi_irq};
  wire [28:0] hw_set = map_sources(int_src, pin_rise);

  // APB decode; writes land on the edge that completes the access phase
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  wire [31:0] pwdata_q = pwdata;
  wire hit_req = paddr == vipu_pkg::OFS_REQ;
  wire hit_mask = paddr == vipu_pkg::OFS_MASK;
  wire hit_level = paddr == vipu_pkg::OFS_LEVEL;
  wire hit_ctrl = paddr == vipu_pkg::OFS_CTRL;
  wire hit_uv = paddr == vipu_pkg::OFS_UVCTRL;
  wire hit_status = paddr == vipu_pkg::OFS_STATUS;
  wire mapped = hit_req | hit_mask | hit_level | hit_ctrl | hit_uv | hit_status;
  // Status is read only, so a write to it is an error as well
  wire bad_access = ~mapped | (pwrite & hit_status);

  // Acceptance of the offered interrupt by the CPU
  wire accept = (state == vipu_pkg::VIPU_OFFER) & cpu_int_ack;
  wire accept_mask = accept & ~offer_trap;
  wire accept_hi = accept_mask & ~level_select_flag[offer_slot];
  wire accept_lo = accept_mask & level_select_flag[offer_slot];
  // Return unwinds the high level first since low can never nest on high
  wire ret_hi = cpu_reti & (hi_depth != '0);
  wire ret_lo = cpu_reti & (hi_depth == '0) & (lo_depth != '0);
  wire [28:0] ack_clr = accept_mask ? (29'h00000001 << offer_slot) : 29'h00000000;

  // Request flags: hardware set wins over both the acknowledge clear and a software write
  wire [28:0] next_req = apb_wr & hit_req
    ? (pwdata_q[28:0] | hw_set)
    : ((req_flags & ~ack_clr) | hw_set);

  // Global enable drops on every acceptance; a software write in the same cycle wins
  wire next_gen = (apb_wr & hit_ctrl) ? pwdata_q[vipu_pkg::CTRL_GEN_BIT]
    : (global_enable_flag & ~accept);

  // Trap pending: new trap wins over the acknowledge of the previous one
  wire next_trap = trap_instruction | (trap_pend & ~(accept & offer_trap));

  // In-service depth bookkeeping
  wire [NEST_W-1:0] next_hi = hi_depth + NEST_W'(accept_hi) - NEST_W'(ret_hi);
  wire [NEST_W-1:0] next_lo = lo_depth + NEST_W'(accept_lo) - NEST_W'(ret_lo);

  // Arbiter inputs
  assign arb_bus.req_flags = req_flags;
  assign arb_bus.mask = mask_flag;
  assign arb_bus.level = level_select_flag;
  assign arb_bus.global_en = global_enable_flag;
  assign arb_bus.hi_busy = hi_depth != '0;
  assign arb_bus.lo_busy = lo_depth != '0;

  // Status word and read mux
  wire in_service_level_flag = hi_depth == '0;
  wire [31:0] status_word = {3'h0, 1'b0, 4'(hi_depth), 4'(lo_depth), 1'b0,
    in_service_level_flag, trap_pend, cpu_int_req, cpu_vector};
  wire [31:0] rd_mux =
    hit_req ? {3'h0, req_flags} :
    hit_mask ? {3'h0, mask_flag} :
    hit_level ? {3'h0, level_select_flag} :
    hit_ctrl ? {30'h00000000, carrier_mode, global_enable_flag} :
    hit_uv ? {30'h00000000, undervoltage_reset_select, 1'b0} :
    hit_status ? status_word : 32'h00000000;

  // Pin synchroniser; only the second and third stages feed the edge detector
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      pin_prev <= 8'h00;
    end
    else if (ce)
    begin
      pin_meta <= external_pin_irqs;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // APB answer: ready in the first access cycle, so no wait states
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (ce)
    begin
      pready <= apb_setup;
      pslverr <= apb_setup & bad_access;
      prdata <= (apb_setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Software-owned configuration
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mask_flag <= vipu_pkg::MASK_RESET;
      level_select_flag <= vipu_pkg::LEVEL_RESET;
      carrier_mode <= 1'b0;
      undervoltage_reset_select <= 1'b0;
    end
    else if (ce & apb_wr)
    begin
      if (hit_mask)
      begin
        mask_flag <= pwdata_q[28:0];
      end
      if (hit_level)
      begin
        level_select_flag <= pwdata_q[28:0];
      end
      if (hit_ctrl)
      begin
        carrier_mode <= pwdata_q[vipu_pkg::CTRL_CARRIER_BIT];
      end
      if (hit_uv)
      begin
        undervoltage_reset_select <= pwdata_q[vipu_pkg::UV_RESET_BIT];
      end
    end
  end

  // Flags, enable, trap and in-service depth
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      req_flags <= vipu_pkg::REQ_RESET;
      global_enable_flag <= 1'b0;
      trap_pend <= 1'b0;
      hi_depth <= '0;
      lo_depth <= '0;
    end
    else if (ce)
    begin
      req_flags <= next_req;
      global_enable_flag <= next_gen;
      trap_pend <= next_trap;
      hi_depth <= next_hi;
      lo_depth <= next_lo;
    end
  end

  // Offer machine: trap first, regardless of enable and levels, then the arbiter winner
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= vipu_pkg::VIPU_IDLE;
      cpu_int_req <= 1'b0;
      cpu_vector <= vipu_pkg::RESET_VECTOR;
      offer_trap <= 1'b0;
      offer_slot <= 5'h00;
    end
    else if (ce)
    begin
      case (state)
        vipu_pkg::VIPU_IDLE:
        begin
          if (trap_pend)
          begin
            state <= vipu_pkg::VIPU_OFFER;
            cpu_int_req <= 1'b1;
            cpu_vector <= vipu_pkg::TRAP_VECTOR;
            offer_trap <= 1'b1;
          end
          else if (arb_bus.grant_valid)
          begin
            state <= vipu_pkg::VIPU_OFFER;
            cpu_int_req <= 1'b1;
            cpu_vector <= slot_vector(arb_bus.grant_slot);
            offer_trap <= 1'b0;
            offer_slot <= arb_bus.grant_slot;
          end
        end
        vipu_pkg::VIPU_OFFER:
        begin
          // The offer stands until taken; a rejected offer would lose the trap
          if (cpu_int_ack)
          begin
            state <= vipu_pkg::VIPU_IDLE;
            cpu_int_req <= 1'b0;
          end
        end
        default:
        begin
          state <= vipu_pkg::VIPU_IDLE;
          cpu_int_req <= 1'b0;
        end
      endcase
    end
  end

  // Standby release ignores the global enable so a masked-off CPU still wakes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      standby_release <= 1'b0;
      sys_reset_req <= 1'b0;
    end
    else if (ce)
    begin
      standby_release <= |(req_flags & ~mask_flag);
      sys_reset_req <= watchdog_overflow
        | (internal_irqs[vipu_pkg::LVI_INT_IDX] & undervoltage_reset_select);
    end
  end

endmodule
`default_nettype wire

// ==== pkg/vipu_pkg.sv ====
// Package with the slot map, register map and constants of the interrupt priority unit
`default_nettype none
package vipu_pkg;

  // Slot and source counts
  localparam int NUM_SLOTS = 29;
  localparam int NUM_EXT = 8;
  localparam int NUM_INT = 29;
  localparam int SLOT_W = 5;

  // Internal source index to slot; two sources landing on one slot share its flag
  localparam logic [4:0] INT_SLOT [0:28] = '{
    5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b,
    5'h0c, 5'h0d, 5'h0e, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
    5'h15, 5'h16, 5'h17, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c};
  // External pin index to slot
  localparam logic [4:0] EXT_SLOT [0:7] = '{
    5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0f, 5'h10};

  // Special sources
  localparam int LVI_INT_IDX = 0;
  localparam int TM8_INT_IDX = 24;

  // Vector table
  localparam logic [15:0] VEC_BASE = 16'h0004;
  localparam logic [15:0] TRAP_VECTOR = 16'h003e;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Register byte offsets
  localparam logic [7:0] OFS_REQ = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_LEVEL = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_UVCTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Field positions
  localparam int CTRL_GEN_BIT = 0;
  localparam int CTRL_CARRIER_BIT = 1;
  localparam int UV_RESET_BIT = 1;
  localparam int ST_REQ_BIT = 16;
  localparam int ST_TRAP_BIT = 17;
  localparam int ST_ISP_BIT = 18;
  localparam int ST_LO_LSB = 20;
  localparam int ST_HI_LSB = 24;

  // Reset values
  localparam logic [28:0] REQ_RESET = 29'h00000000;
  localparam logic [28:0] MASK_RESET = 29'h1fffffff;
  localparam logic [28:0] LEVEL_RESET = 29'h1fffffff;

  // Offer state machine
  typedef enum logic [1:0] {
    VIPU_IDLE = 2'b01,
    VIPU_OFFER = 2'b10
  } vipu_state_t;

  // Lowest set index of a slot vector, the highest default priority
  function automatic logic [5:0] vipu_first_set(input logic [28:0] vec);
    logic [5:0] res;
    res = 6'h00;
    for (int i = NUM_SLOTS - 1; i >= 0; i--)
    begin
      if (vec[i])
      begin
        res = {1'b1, i[4:0]};
      end
    end
    return res;
  endfunction

endpackage
`default_nettype wire

// ==== pkg/vipu_arb_if.sv ====
// Interface between the register core and the priority arbiter
`timescale 1ns/10ps
`default_nettype none
interface vipu_arb_if;
  logic [28:0] req_flags;
  logic [28:0] mask;
  logic [28:0] level;
  logic global_en;
  logic hi_busy;
  logic lo_busy;
  logic grant_valid;
  logic [4:0] grant_slot;

  modport core (output req_flags, mask, level, global_en, hi_busy, lo_busy,
                input grant_valid, grant_slot);
  modport arb (input req_flags, mask, level, global_en, hi_busy, lo_busy,
               output grant_valid, grant_slot);
endinterface
`default_nettype wire

// ==== logic/vipu_arbiter.sv ====
// Two-group priority arbiter choosing the winning maskable slot
`timescale 1ns/10ps
`default_nettype none
module vipu_arbiter (
  vipu_arb_if.arb arb
);

  // Pending, unmasked and globally enabled requests
  wire [28:0] eligible = arb.req_flags & ~arb.mask & {29{arb.global_en}};
  // Level flag 0 means high group; nothing maskable passes a high service
  wire [28:0] hi_cand = eligible & ~arb.level & {29{~arb.hi_busy}};
  // Low group waits while any service routine runs
  wire [28:0] lo_cand = eligible & arb.level & {29{~arb.hi_busy & ~arb.lo_busy}};
  wire [5:0] hi_pick = vipu_pkg::vipu_first_set(hi_cand);
  wire [5:0] lo_pick = vipu_pkg::vipu_first_set(lo_cand);

  // High group first, then fixed order within the group
  assign arb.grant_valid = hi_pick[5] | lo_pick[5];
  assign arb.grant_slot = hi_pick[5] ? hi_pick[4:0] : lo_pick[4:0];

endmodule
`default_nettype wire

// ==== testbench/vipu_checker.sv ====
// Concurrent checks on the ports of the interrupt priority unit
`timescale 1ns/10ps
`default_nettype none
module vipu_checker (
  // Clock, reset and bus handshake
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Sources and CPU side
  input wire logic [28:0] internal_irqs,
  input wire logic watchdog_overflow,
  input wire logic trap_instruction,
  input wire logic cpu_int_ack,
  input wire logic cpu_int_req,
  input wire logic [15:0] cpu_vector,
  input wire logic standby_release,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Trap seen with no offer standing, then one more idle edge
  sequence trap_seen;
    ce && trap_instruction && !cpu_int_req;
  endsequence
  sequence still_idle;
    ce && !cpu_int_req;
  endsequence

  // Zero-wait slave answers in the first access cycle
  chk_apb_ready: assert property (ce && psel && !penable |=> pready)
    else $error("ready late");
  chk_offer_holds: assert property (ce && cpu_int_req && !cpu_int_ack
    |=> cpu_int_req && $stable(cpu_vector))
    else $error("offer moved");
  // A pending trap may be offered on the edge after the idle one
  chk_ack_clears: assert property (ce && cpu_int_req && cpu_int_ack
    |=> !cpu_int_req)
    else $error("offer after accept");
  chk_vector_legal: assert property (cpu_int_req |-> cpu_vector == 16'h003e
    || (cpu_vector >= 16'h0004 && cpu_vector <= 16'h003c && !cpu_vector[0]))
    else $error("bad vector");
  chk_trap_offer: assert property (trap_seen ##1 still_idle
    |=> cpu_int_req && cpu_vector == 16'h003e)
    else $error("trap not offered");
  chk_wdt_reset: assert property (ce && watchdog_overflow |=> sys_reset_req)
    else $error("no watchdog reset");
  chk_reset_cause: assert property (sys_reset_req
    |-> $past(watchdog_overflow) || $past(internal_irqs[0]))
    else $error("reset without cause");
  // Trap offers need no pending flag, so they are left out
  chk_offer_wakes: assert property ($rose(cpu_int_req) && cpu_vector != 16'h003e
    |-> standby_release)
    else $error("offer without wake");
endmodule

bind vipu_top vipu_checker vipu_checker_i (.sys_clk, .rst, .ce, .psel, .penable,
  .pready, .internal_irqs, .watchdog_overflow, .trap_instruction, .cpu_int_ack,
  .cpu_int_req, .cpu_vector, .standby_release, .sys_reset_req);
`default_nettype wire

// ==== testbench/vipu_cpu_model.sv ====
// CPU core model that accepts interrupt offers
`timescale 1ns/10ps
`default_nettype none
module vipu_cpu_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Accept delay and offer handshake
  input wire logic [3:0] ack_wait,
  input wire logic cpu_int_req,
  output logic cpu_int_ack
);
  logic [3:0] wait_cnt;

  // One accept pulse per offer; a slow core waits first
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_int_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (cpu_int_ack)
    begin
      cpu_int_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (cpu_int_req)
    begin
      cpu_int_ack <= wait_cnt >= ack_wait;
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the interrupt priority unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, external_pin_irqs = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [28:0] internal_irqs = 29'h0;
  logic carrier_combined_irq = 1'b0, watchdog_overflow = 1'b0;
  logic trap_instruction = 1'b0, cpu_reti = 1'b0, ce = 1'b1;
  logic [3:0] ack_wait = 4'h0;
  logic [15:0] cpu_vector;
  logic pready, pslverr, errv, cpu_int_ack, cpu_int_req, standby_release, sys_reset_req;
  int n_errors = 0;
  int checked = 0;

  vipu_top vipu_top_i (.sys_clk, .rst, .ce, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .external_pin_irqs, .internal_irqs,
    .carrier_combined_irq, .watchdog_overflow, .trap_instruction, .cpu_int_ack,
    .cpu_reti, .cpu_int_req, .cpu_vector, .standby_release, .sys_reset_req);
  vipu_cpu_model vipu_cpu_model_i (.sys_clk, .rst, .ack_wait, .cpu_int_req,
    .cpu_int_ack);

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  task automatic summarize;
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Request held until ready; a free edge after keeps drivers apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {pwrite, paddr, pwdata, psel} <= {w, a, d, 1'b1};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {rdv, errv} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(s, e, rdv);
  endtask
  task automatic en(input logic [31:0] d);
    apb(1'b1, vipu_pkg::OFS_CTRL, d);
  endtask
  task automatic pulse(input logic [28:0] m);
    internal_irqs <= m;
    @(posedge sys_clk);
    internal_irqs <= 29'h0;
    @(posedge sys_clk);
  endtask
  // Wait for an accepted offer, then compare what was taken
  task automatic take(input logic [15:0] e);
    for (int n = 0; n < 20 && cpu_int_ack !== 1'b1; n++)
      @(posedge sys_clk);
    cmp("vector", {16'h1, e}, {15'h0, cpu_int_ack, cpu_vector});
    @(posedge sys_clk);
  endtask
  task automatic quiet(input logic sb);
    repeat (6) @(posedge sys_clk);
    cmp("offer,wake", {31'h0, sb}, {30'h0, cpu_int_req, standby_release});
  endtask
  task automatic ret;
    cpu_reti <= 1'b1;
    @(posedge sys_clk);
    cpu_reti <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic t_regs;
    rchk("mask", vipu_pkg::OFS_MASK, 32'h1fffffff);
    rchk("level", vipu_pkg::OFS_LEVEL, 32'h1fffffff);
    apb(1'b0, 8'h18, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, errv});
  endtask
  // Seven sources alone, then two equal-level sources at once
  task automatic t_order;
    int idx [7] = '{16, 19, 21, 22, 23, 26, 28};
    logic [15:0] v [7] = '{16'h0026, 16'h002c, 16'h0030, 16'h0032, 16'h0032,
      16'h0038, 16'h003c};
    apb(1'b1, vipu_pkg::OFS_MASK, 32'h0);
    for (int k = 0; k < 7; k++)
    begin
      en(32'h1);
      pulse(29'h1 << idx[k]);
      take(v[k]);
      rchk("req", vipu_pkg::OFS_REQ, 32'h0);
      ret();
    end
    en(32'h1);
    pulse(29'h10010000);
    take(16'h0026);
    ret();
    en(32'h1);
    take(16'h003c);
    ret();
  endtask
  task automatic t_mask;
    apb(1'b1, vipu_pkg::OFS_MASK, 32'h00400000);
    en(32'h1);
    pulse(29'h1 << 21);
    quiet(1'b0);
    en(32'h0);
    apb(1'b1, vipu_pkg::OFS_MASK, 32'h0);
    quiet(1'b1);
    en(32'h1);
    take(16'h0030);
    ret();
  endtask
  // Slot 28 high: it beats slot 26 and nests into a low routine
  task automatic t_nest;
    ack_wait <= 4'h5;
    apb(1'b1, vipu_pkg::OFS_LEVEL, 32'h0fffffff);
    en(32'h1);
    pulse(29'h1 << 19);
    take(16'h002c);
    pulse(29'h1 << 26);
    quiet(1'b1);
    pulse(29'h1 << 28);
    en(32'h1);
    take(16'h003c);
    en(32'h1);
    quiet(1'b1);
    ret();
    quiet(1'b1);
    ret();
    take(16'h0038);
    ret();
    apb(1'b1, vipu_pkg::OFS_LEVEL, 32'h1fffffff);
    ack_wait <= 4'h0;
  endtask
  // Trap taken inside a low routine with global enable off
  task automatic t_trap;
    en(32'h1);
    pulse(29'h1 << 19);
    take(16'h002c);
    rchk("status", vipu_pkg::OFS_STATUS, 32'h0014002c);
    trap_instruction <= 1'b1;
    @(posedge sys_clk);
    trap_instruction <= 1'b0;
    take(16'h003e);
    ret();
  endtask
  task automatic t_src;
    logic [4:0] s [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0f, 5'h10};
    en(32'h2);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, vipu_pkg::OFS_REQ, 32'h0);
      external_pin_irqs <= 8'h1 << k;
      repeat (4) @(posedge sys_clk);
      external_pin_irqs <= 8'h0;
      rchk("pin", vipu_pkg::OFS_REQ, 32'h1 << s[k]);
    end
    apb(1'b1, vipu_pkg::OFS_REQ, 32'h0);
    pulse(29'h1 << 24);
    rchk("match", vipu_pkg::OFS_REQ, 32'h0);
    carrier_combined_irq <= 1'b1;
    @(posedge sys_clk);
    carrier_combined_irq <= 1'b0;
    rchk("carrier", vipu_pkg::OFS_REQ, 32'h01000000);
  endtask
  task automatic t_lvi;
    apb(1'b1, vipu_pkg::OFS_REQ, 32'h0);
    pulse(29'h1);
    rchk("uv flag", vipu_pkg::OFS_REQ, 32'h1);
    apb(1'b1, vipu_pkg::OFS_REQ, 32'h0);
    apb(1'b1, vipu_pkg::OFS_UVCTRL, 32'h2);
    for (int k = 0; k < 2; k++)
    begin
      {watchdog_overflow, internal_irqs} <= {k[0], 28'h0, !k[0]};
      @(posedge sys_clk);
      {watchdog_overflow, internal_irqs} <= 30'h0;
      @(posedge sys_clk);
      cmp("reset", 32'h1, {31'h0, sys_reset_req});
    end
    rchk("uv flag", vipu_pkg::OFS_REQ, 32'h0);
  endtask

  // Frozen clock enable: a source pulse leaves no flag behind
  task automatic t_ce;
    apb(1'b1, vipu_pkg::OFS_REQ, 32'h0);
    ce <= 1'b0;
    pulse(29'h1 << 25);
    ce <= 1'b1;
    rchk("frozen", vipu_pkg::OFS_REQ, 32'h0);
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_order();
    t_mask();
    t_nest();
    t_trap();
    t_src();
    t_lvi();
    t_ce();
    summarize();
  end
  // Run needs about 400 cycles; cut a hang well past that
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
